/* gcd_defs.svh */
// Offsets, field positions, reset values and timing counts of the global configuration block.
// Assumes inclusion by bare name from the design modules and the checker.
`ifndef GCD_DEFS_SVH
`define GCD_DEFS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define GCD_OFS_GLOBAL_CFG 12'h000
`define GCD_OFS_UPPER_ADDR 12'h004
`define GCD_OFS_STATUS 12'h008

// ****************************************
// Global configuration fields
// ****************************************
`define GCD_GC_GAP_HI 14
`define GCD_GC_GAP_LO 12
`define GCD_GC_CLK_EN 11
`define GCD_GC_STYLE 10
`define GCD_GC_ASTR_HI 9
`define GCD_GC_ASTR_LO 8
`define GCD_GC_DSTR_HI 6
`define GCD_GC_DSTR_LO 4
`define GCD_GC_MASK_A 3
`define GCD_GC_MASK_B 2
`define GCD_GC_MAP_HI 1
`define GCD_GC_MAP_LO 0
`define GCD_GC_WMASK 32'h0000_7f7f

// ****************************************
// Reset values
// ****************************************
`define GCD_GC_RESET 32'h0000_0000
`define GCD_UPPER_RESET 32'h0000_0000

// ****************************************
// Timing counts and codes
// ****************************************
`define GCD_MCLK_PERIOD_NS 8
`define GCD_GAP_BASE 4'h4
`define GCD_CMD_DUAL 4'hd

`endif

/* gcd_pkg.sv */
// Types shared by the global configuration block and its expansion bus sequencer.
// Assumes gcd_defs.svh holds the constants.
package gcd_pkg;
  typedef enum logic [1:0] {
    GCD_MAP_DIRECT,
    GCD_MAP_PAIRS,
    GCD_MAP_QUADS,
    GCD_MAP_RSVD
  } gcd_map_e;

  typedef enum {
    GCD_PCI_IDLE,
    GCD_PCI_ADDR_LOW,
    GCD_PCI_ADDR_HIGH
  } gcd_pci_state_e;

  typedef enum {
    GCD_EXP_IDLE,
    GCD_EXP_REQ,
    GCD_EXP_ADDR,
    GCD_EXP_DATA,
    GCD_EXP_GAP
  } gcd_exp_state_e;
endpackage

/* gcd_exp_if.sv */
// Carrier between the configuration block and its expansion bus sequencer.
// Assumes one clock domain; the configuration side owns the settings and the requests.
`timescale 1ns/1ps
interface gcd_exp_if #(
  parameter int AW = 16
);
  logic style;
  logic [1:0] addr_stretch;
  logic [2:0] data_stretch;
  logic [2:0] gap;
  logic req;
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic done;
  logic busy;
  logic [7:0] rdata;

  modport cfg (
    output style, addr_stretch, data_stretch, gap, req, we, addr, wdata,
    input done, busy, rdata
  );
  modport seq (
    input style, addr_stretch, data_stretch, gap, req, we, addr, wdata,
    output done, busy, rdata
  );
endinterface

/* gcd_exp_seq.sv */
// Expansion bus sequencer: arbitration, stretched address and data phases, release gap.
// Assumes the expansion clock is the inverted host clock, so one period is one mclk cycle.
`timescale 1ns/1ps
`include "gcd_defs.svh"
module gcd_exp_seq
  import gcd_pkg::*;
#(
  parameter int AW = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Settings and requests
  gcd_exp_if.seq ctl,
  // Expansion bus pins
  output logic exp_bus_req_o,
  input wire logic exp_bus_grant_i,
  output logic exp_addr_strobe_n,
  output logic exp_dir_o,
  output logic exp_data_strobe_n,
  output logic [AW-1:0] exp_addr_o,
  output logic [7:0] exp_data_o,
  output logic exp_data_oe,
  input wire logic [7:0] exp_data_i
);
  gcd_exp_state_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic we_r;
  logic style_r;

  // Grant polarity follows the latched style: low grant, or high hold acknowledge
  wire granted = style_r ? exp_bus_grant_i : ~exp_bus_grant_i;
  wire cnt_zero = (cnt_r == 4'h0);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_zero ? 4'h0 : cnt_r - 4'h1;
    case (state_r)
      GCD_EXP_IDLE: begin
        if (ctl.req) begin
          state_nxt = GCD_EXP_REQ;
        end
      end
      GCD_EXP_REQ: begin
        if (granted) begin
          state_nxt = GCD_EXP_ADDR;
          cnt_nxt = {2'b00, ctl.addr_stretch};
        end
      end
      GCD_EXP_ADDR: begin
        if (cnt_zero) begin
          state_nxt = GCD_EXP_DATA;
          cnt_nxt = {1'b0, ctl.data_stretch};
        end
      end
      GCD_EXP_DATA: begin
        if (cnt_zero) begin
          state_nxt = GCD_EXP_GAP;
          cnt_nxt = {1'b0, ctl.gap} + `GCD_GAP_BASE - 4'h1;
        end
      end
      GCD_EXP_GAP: begin
        if (cnt_zero) begin
          state_nxt = GCD_EXP_IDLE;
        end
      end
      default: begin
        state_nxt = GCD_EXP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= GCD_EXP_IDLE;
      cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************
  // Latched request and pin drive
  // ****************************************
  // Style is latched per access so a mid-access write cannot flip pin meaning
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      we_r <= 1'b0;
      style_r <= 1'b0;
      exp_addr_o <= '0;
      exp_data_o <= 8'h00;
    end else if (state_r == GCD_EXP_IDLE && ctl.req) begin
      we_r <= ctl.we;
      style_r <= ctl.style;
      exp_addr_o <= ctl.addr;
      exp_data_o <= ctl.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctl.rdata <= 8'h00;
    end else if (state_r == GCD_EXP_DATA && cnt_zero && !we_r) begin
      ctl.rdata <= exp_data_i;
    end
  end

  wire in_addr = (state_r == GCD_EXP_ADDR);
  wire in_data = (state_r == GCD_EXP_DATA);
  wire owning = (state_r != GCD_EXP_IDLE) && (state_r != GCD_EXP_GAP);

  // Idle level follows the live style, so a style change never shows a false request
  assign exp_bus_req_o = owning ? style_r : ~ctl.style;
  assign exp_addr_strobe_n = ~in_data;
  assign exp_dir_o = style_r ? ~(in_data && cnt_zero && we_r) : ~we_r;
  assign exp_data_strobe_n = ~(in_data && cnt_zero && (style_r || !we_r));
  assign exp_data_oe = we_r && (in_addr || in_data);
  assign ctl.done = in_data && cnt_zero;
  assign ctl.busy = (state_r != GCD_EXP_IDLE);
endmodule

/* gcd_global_cfg.sv */
// Global configuration block: AHB-Lite register slave, expansion clock, bus style and
// stretching, interrupt masks, port-to-group mapping and host-bus dual addressing.
// Assumes one 125 MHz host clock, single-word AHB transfers and synchronous inputs.
`timescale 1ns/1ps
`include "gcd_defs.svh"

// What this block does
// - Clock enable low: expansion clock pin floats
// - Clock enable high: drive inverted host clock
// - Style 0: request, grant, strobe, direction, read
// - Address held stretch plus one periods
// - Data held stretch plus one periods
// - Mapping 0: port n to group n
// - Mapping 1: port k to groups 2k, 2k+1
// - Mapping 2: quads per port; 3 reserved
// - Nonzero upper base selects dual addressing
// - Single address: one-clock address phase
// - Dual address: two clocks, dual command first, unless the command is itself the dual command
// - Upper address bits from upper base register
// - Target answers only single-address cycles
// - Wait gap plus four before new request
module gcd_global_cfg
  import gcd_pkg::*;
#(
  parameter int EXP_AW = 16,
  parameter int GROUPS = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Expansion clock pin
  output logic exp_bus_clock_o,
  output logic exp_bus_clock_oe,
  // Expansion access requests
  input wire logic exp_req,
  input wire logic exp_we,
  input wire logic [EXP_AW-1:0] exp_addr,
  input wire logic [7:0] exp_wdata,
  output logic exp_done,
  output logic [7:0] exp_rdata,
  // Expansion bus pins
  output logic exp_bus_req_o,
  input wire logic exp_bus_grant_i,
  output logic exp_addr_strobe_n,
  output logic exp_dir_o,
  output logic exp_data_strobe_n,
  output logic [EXP_AW-1:0] exp_addr_o,
  output logic [7:0] exp_data_o,
  output logic exp_data_oe,
  input wire logic [7:0] exp_data_i,
  // Interrupt lines, open drain
  input wire logic irq_a_req,
  input wire logic irq_b_req,
  output logic irq_a_n_o,
  output logic irq_a_n_oe,
  output logic irq_b_n_o,
  output logic irq_b_n_oe,
  // Port to group mapping
  output logic [GROUPS*3-1:0] group_port_sel,
  output logic [GROUPS-1:0] group_enable,
  // Host bus master address phase
  input wire logic mst_req,
  input wire logic [3:0] mst_cmd,
  input wire logic [31:0] mst_addr,
  output logic mst_ready,
  output logic mst_addr_done,
  output logic [31:0] pci_ad_o,
  output logic pci_ad_oe,
  output logic [3:0] pci_cbe_n_o,
  output logic pci_cbe_oe,
  output logic pci_frame_n_o,
  // Host bus target decode
  input wire logic tgt_addr_valid,
  input wire logic [3:0] tgt_cmd,
  output logic tgt_claim
);
  initial begin
    if (GROUPS != 8) begin
      $error("gcd_global_cfg: GROUPS must be 8");
    end
    if (EXP_AW < 1 || EXP_AW > 32) begin
      $error("gcd_global_cfg: EXP_AW out of range");
    end
  end

  // ****************************************
  // Register bus slave
  // ****************************************
  logic [31:0] gcfg_r;
  logic [31:0] upper_r;
  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] status_w;
  logic [31:0] rd_mux_w;
  logic [31:0] gcfg_nxt;
  logic [31:0] upper_nxt;

  // Zero wait states, so every address phase is accepted
  wire addr_phase = hsel && hready && htrans[1];
  wire wr_gcfg = wr_pend_r && (wr_addr_r == `GCD_OFS_GLOBAL_CFG);
  wire wr_upper = wr_pend_r && (wr_addr_r == `GCD_OFS_UPPER_ADDR);
  wire sel_gcfg = (haddr == `GCD_OFS_GLOBAL_CFG);
  wire sel_upper = (haddr == `GCD_OFS_UPPER_ADDR);
  wire sel_status = (haddr == `GCD_OFS_STATUS);

  assign gcfg_nxt = wr_gcfg ? (hwdata & `GCD_GC_WMASK) : gcfg_r;
  assign upper_nxt = wr_upper ? hwdata : upper_r;

  // Forwarded next values keep a read right after a write coherent
  assign rd_mux_w = sel_gcfg ? gcfg_nxt :
                    sel_upper ? upper_nxt :
                    sel_status ? status_w : 32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      wr_addr_r <= haddr;
      if (addr_phase && !hwrite) begin
        hrdata_r <= rd_mux_w;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gcfg_r <= `GCD_GC_RESET;
      upper_r <= `GCD_UPPER_RESET;
    end else begin
      gcfg_r <= gcfg_nxt;
      upper_r <= upper_nxt;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ****************************************
  // Configuration fields
  // ****************************************
  wire clk_out_en = gcfg_r[`GCD_GC_CLK_EN];
  wire style_sel = gcfg_r[`GCD_GC_STYLE];
  wire mask_a = gcfg_r[`GCD_GC_MASK_A];
  wire mask_b = gcfg_r[`GCD_GC_MASK_B];
  gcd_map_e map_mode;
  assign map_mode = gcd_map_e'(gcfg_r[`GCD_GC_MAP_HI:`GCD_GC_MAP_LO]);
  wire dual_mode = (upper_r != 32'h0000_0000);

  // ****************************************
  // Expansion clock pin
  // ****************************************
  // The clock pin is a combinational inversion of mclk, not a plain redrive
  assign exp_bus_clock_o = ~mclk;
  assign exp_bus_clock_oe = clk_out_en;

  // ****************************************
  // Expansion bus sequencer
  // ****************************************
  gcd_exp_if #(.AW(EXP_AW)) exp_ch ();

  assign exp_ch.style = style_sel;
  assign exp_ch.addr_stretch = gcfg_r[`GCD_GC_ASTR_HI:`GCD_GC_ASTR_LO];
  assign exp_ch.data_stretch = gcfg_r[`GCD_GC_DSTR_HI:`GCD_GC_DSTR_LO];
  assign exp_ch.gap = gcfg_r[`GCD_GC_GAP_HI:`GCD_GC_GAP_LO];
  assign exp_ch.req = exp_req;
  assign exp_ch.we = exp_we;
  assign exp_ch.addr = exp_addr;
  assign exp_ch.wdata = exp_wdata;
  assign exp_done = exp_ch.done;
  assign exp_rdata = exp_ch.rdata;

  gcd_exp_seq #(.AW(EXP_AW)) u_exp_seq (
    .mclk(mclk),
    .rst_n(rst_n),
    .ctl(exp_ch.seq),
    .exp_bus_req_o(exp_bus_req_o),
    .exp_bus_grant_i(exp_bus_grant_i),
    .exp_addr_strobe_n(exp_addr_strobe_n),
    .exp_dir_o(exp_dir_o),
    .exp_data_strobe_n(exp_data_strobe_n),
    .exp_addr_o(exp_addr_o),
    .exp_data_o(exp_data_o),
    .exp_data_oe(exp_data_oe),
    .exp_data_i(exp_data_i)
  );

  // ****************************************
  // Interrupt lines
  // ****************************************
  logic irq_a_drive_r;
  logic irq_b_drive_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_a_drive_r <= 1'b0;
      irq_b_drive_r <= 1'b0;
    end else begin
      irq_a_drive_r <= irq_a_req && !mask_a;
      irq_b_drive_r <= irq_b_req && !mask_b;
    end
  end

  assign irq_a_n_o = 1'b0;
  assign irq_b_n_o = 1'b0;
  assign irq_a_n_oe = irq_a_drive_r;
  assign irq_b_n_oe = irq_b_drive_r;

  // ****************************************
  // Port to group mapping
  // ****************************************
  // Reserved mapping leaves every group unconnected rather than guessing
  logic [GROUPS*3-1:0] port_sel_r;
  logic [GROUPS-1:0] group_en_r;

  for (genvar g = 0; g < GROUPS; g++) begin : g_map
    logic [2:0] gidx;
    logic [2:0] sel_w;
    assign gidx = 3'(g);
    assign sel_w = (map_mode == GCD_MAP_DIRECT) ? gidx :
                   (map_mode == GCD_MAP_PAIRS) ? {1'b0, gidx[2:1]} :
                   (map_mode == GCD_MAP_QUADS) ? {2'b00, gidx[2]} : 3'h0;
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        port_sel_r[g*3 +: 3] <= 3'h0;
        group_en_r[g] <= 1'b0;
      end else begin
        port_sel_r[g*3 +: 3] <= sel_w;
        group_en_r[g] <= (map_mode != GCD_MAP_RSVD);
      end
    end
  end

  assign group_port_sel = port_sel_r;
  assign group_enable = group_en_r;

  // ****************************************
  // Host bus master address phase
  // ****************************************
  gcd_pci_state_e pst_r, pst_nxt;
  logic [31:0] ad_r, ad_nxt;
  logic [3:0] cbe_r, cbe_nxt;
  logic [3:0] cmd_r;
  logic done_r;

  always_comb begin
    pst_nxt = pst_r;
    ad_nxt = ad_r;
    cbe_nxt = cbe_r;
    case (pst_r)
      GCD_PCI_IDLE: begin
        if (mst_req) begin
          pst_nxt = GCD_PCI_ADDR_LOW;
          ad_nxt = mst_addr;
          cbe_nxt = dual_mode ? `GCD_CMD_DUAL : mst_cmd;
        end
      end
      GCD_PCI_ADDR_LOW: begin
        if (cbe_r == `GCD_CMD_DUAL && cmd_r != `GCD_CMD_DUAL) begin
          pst_nxt = GCD_PCI_ADDR_HIGH;
          ad_nxt = upper_r;
          cbe_nxt = cmd_r;
        end else begin
          pst_nxt = GCD_PCI_IDLE;
        end
      end
      GCD_PCI_ADDR_HIGH: begin
        pst_nxt = GCD_PCI_IDLE;
      end
      default: begin
        pst_nxt = GCD_PCI_IDLE;
      end
    endcase
  end

  wire addr_last = (pst_r == GCD_PCI_ADDR_HIGH) ||
                   ((pst_r == GCD_PCI_ADDR_LOW) && (pst_nxt == GCD_PCI_IDLE));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pst_r <= GCD_PCI_IDLE;
      ad_r <= 32'h0000_0000;
      cbe_r <= 4'h0;
      cmd_r <= 4'h0;
      done_r <= 1'b0;
    end else begin
      pst_r <= pst_nxt;
      ad_r <= ad_nxt;
      cbe_r <= cbe_nxt;
      done_r <= addr_last;
      if (pst_r == GCD_PCI_IDLE && mst_req) begin
        cmd_r <= mst_cmd;
      end
    end
  end

  wire in_addr = (pst_r != GCD_PCI_IDLE);

  assign mst_ready = (pst_r == GCD_PCI_IDLE);
  assign mst_addr_done = done_r;
  assign pci_ad_o = ad_r;
  assign pci_ad_oe = in_addr;
  assign pci_cbe_n_o = cbe_r;
  assign pci_cbe_oe = in_addr;
  assign pci_frame_n_o = ~in_addr;

  // ****************************************
  // Host bus target decode
  // ****************************************
  logic claim_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      claim_r <= 1'b0;
    end else begin
      claim_r <= tgt_addr_valid && (tgt_cmd != `GCD_CMD_DUAL);
    end
  end

  assign tgt_claim = claim_r;

  // ****************************************
  // Status word
  // ****************************************
  assign status_w = {29'h0000_0000, dual_mode, in_addr, exp_ch.busy};
endmodule

/* gcd_global_cfg_assertions.sv */
// Checker on the global configuration block's top ports.
// Assumes one clock; registers are mirrored from observed AHB writes.
`timescale 1ns/1ps
`include "gcd_defs.svh"
module gcd_global_cfg_assertions #(
  parameter int EXP_AW = 16,
  parameter int GROUPS = 8
) (
  // Clock, reset and bus
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  // Watched pins
  input wire logic exp_bus_clock_oe,
  input wire logic exp_done,
  input wire logic exp_bus_req_o,
  input wire logic exp_addr_strobe_n,
  input wire logic exp_data_oe,
  input wire logic irq_a_req,
  input wire logic irq_b_req,
  input wire logic irq_a_n_oe,
  input wire logic irq_b_n_oe,
  input wire logic [GROUPS-1:0] group_enable,
  input wire logic mst_req,
  input wire logic [3:0] mst_cmd,
  input wire logic [31:0] mst_addr,
  input wire logic mst_ready,
  input wire logic mst_addr_done,
  input wire logic [31:0] pci_ad_o,
  input wire logic [3:0] pci_cbe_n_o,
  input wire logic pci_frame_n_o,
  input wire logic tgt_addr_valid,
  input wire logic [3:0] tgt_cmd,
  input wire logic tgt_claim
);
  // ****
  // Register mirror and phase counters
  // ****
  logic wr_r;
  logic [11:0] wa_r;
  logic [31:0] gc_r;
  logic [31:0] ub_r;
  logic [3:0] acnt_r;
  logic [3:0] dcnt_r;
  logic [3:0] gcnt_r;
  logic gc_wr;
  logic ub_wr;
  logic req_on;
  assign gc_wr = wr_r && wa_r == `GCD_OFS_GLOBAL_CFG;
  assign ub_wr = wr_r && wa_r == `GCD_OFS_UPPER_ADDR;
  assign req_on = gc_r[10] ? exp_bus_req_o : !exp_bus_req_o;
  always_ff @(posedge mclk) begin
    wr_r <= rst_n && hsel && hready && htrans[1] && hwrite;
    wa_r <= haddr;
    acnt_r <= (exp_data_oe && exp_addr_strobe_n) ? acnt_r + 4'h1 : 4'h0;
    dcnt_r <= exp_addr_strobe_n ? 4'h0 : dcnt_r + 4'h1;
  end
  // Gap counter starts saturated so the first request is never judged
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gc_r <= 32'h0;
      ub_r <= 32'h0;
      gcnt_r <= 4'hf;
    end else begin
      gc_r <= gc_wr ? (hwdata & 32'h0000_7f7f) : gc_r;
      ub_r <= ub_wr ? hwdata : ub_r;
      gcnt_r <= exp_done ? 4'h0 : gcnt_r + {3'h0, gcnt_r != 4'hf};
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  clk_enable_a: assert property (gc_wr |=> exp_bus_clock_oe == $past(hwdata[11]))
    else $error("clock pin enable does not follow its bit");
  tgt_claim_a: assert property (tgt_addr_valid |=> tgt_claim == ($past(tgt_cmd) != 4'hd))
    else $error("target claim wrong for command");
  mst_single_a: assert property (mst_req && mst_ready && ub_r == 32'h0 |=>
    !pci_frame_n_o && pci_ad_o == $past(mst_addr) && pci_cbe_n_o == $past(mst_cmd) ##1 mst_addr_done)
    else $error("single address phase wrong");
  mst_dual_a: assert property (mst_req && mst_ready && ub_r != 32'h0 && mst_cmd != 4'hd |=>
    pci_cbe_n_o == 4'hd && pci_ad_o == $past(mst_addr) ##1
    pci_ad_o == ub_r && pci_cbe_n_o == $past(mst_cmd, 2) ##1 mst_addr_done)
    else $error("dual address phase wrong");
  irq_mask_a: assert property (irq_a_req && irq_b_req |=>
    {irq_a_n_oe, irq_b_n_oe} == ~$past(gc_r[3:2]))
    else $error("interrupt line ignores its mask");
  map_rsvd_a: assert property (gc_r[1:0] == 2'h3 && $past(gc_r[1:0]) == 2'h3 |-> group_enable == '0)
    else $error("groups enabled under reserved mapping");
  addr_len_a: assert property ($fell(exp_addr_strobe_n) && exp_data_oe |-> acnt_r == gc_r[9:8] + 4'h1)
    else $error("address phase length wrong");
  data_len_a: assert property (exp_done |-> dcnt_r == {1'b0, gc_r[6:4]})
    else $error("data phase length wrong");
  gap_len_a: assert property (req_on && !$past(req_on) |-> gcnt_r >= gc_r[14:12] + 4'h4)
    else $error("bus requested again too soon");
  cover property (mst_req && mst_ready && ub_r != 32'h0);
  cover property (exp_done && gc_r[10]);
  cover property (tgt_claim);
endmodule
bind gcd_global_cfg gcd_global_cfg_assertions #(.EXP_AW(EXP_AW), .GROUPS(GROUPS)) i_chk (
  .mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .exp_bus_clock_oe, .exp_done,
  .exp_bus_req_o, .exp_addr_strobe_n, .exp_data_oe, .irq_a_req, .irq_b_req, .irq_a_n_oe, .irq_b_n_oe,
  .group_enable, .mst_req, .mst_cmd, .mst_addr, .mst_ready, .mst_addr_done, .pci_ad_o, .pci_cbe_n_o,
  .pci_frame_n_o, .tgt_addr_valid, .tgt_cmd, .tgt_claim);

/* gcd_exp_partner.sv */
// Far side of the expansion bus: an arbiter and a byte-wide read responder returning the low address byte XOR 5a.
// Assumes the bench tells it the bus style and the grant lag.
`timescale 1ns/1ps
module gcd_exp_partner (
  // Clock and settings
  input wire logic mclk,
  input wire logic style,
  input wire logic [1:0] lag,
  // Bus pins
  input wire logic exp_bus_req_o,
  input wire logic exp_addr_strobe_n,
  input wire logic exp_data_oe,
  input wire logic [7:0] addr_lo,
  output logic exp_bus_grant_i,
  output logic [7:0] exp_data_i
);
  logic [2:0] cnt_r;
  logic [7:0] last_r = 8'h00;
  logic req_seen;
  logic act;
  logic drive;
  assign req_seen = style ? exp_bus_req_o : !exp_bus_req_o;
  // Grant drops at once with the request, as a real arbiter would
  assign act = req_seen && cnt_r > {1'b0, lag};
  assign exp_bus_grant_i = style ? act : !act;
  // Released lines show the inverse of the last value
  assign drive = !exp_addr_strobe_n && !exp_data_oe;
  assign exp_data_i = drive ? addr_lo ^ 8'h5a : ~last_r;
  always_ff @(posedge mclk) begin
    cnt_r <= req_seen ? cnt_r + {2'h0, cnt_r != 3'h7} : 3'h0;
    last_r <= exp_data_i;
  end
endmodule

/* global_config_and_dual_addr_bench.sv */
// Self-checking bench for the global configuration block over AHB-Lite.
// Assumes the expansion partner model and the bound checker.
`timescale 1ns/1ps
module global_config_and_dual_addr_bench;
  logic mclk, rst_n, hsel, hwrite, hready, hreadyout, hresp, style;
  logic [11:0] haddr;
  logic [1:0] htrans, lag;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd, mst_addr, pci_ad_o;
  logic exp_bus_clock_o, exp_bus_clock_oe, exp_req, exp_we, exp_done, exp_data_oe;
  logic [15:0] exp_addr, exp_addr_o;
  logic [7:0] exp_wdata, exp_rdata, exp_data_o, exp_data_i, group_enable;
  logic exp_bus_req_o, exp_bus_grant_i, exp_addr_strobe_n, exp_dir_o, exp_data_strobe_n;
  logic irq_a_req, irq_b_req, irq_a_n_o, irq_a_n_oe, irq_b_n_o, irq_b_n_oe;
  logic [23:0] group_port_sel, sel_x;
  logic mst_req, mst_ready, mst_addr_done, pci_ad_oe, pci_cbe_oe, pci_frame_n_o, tgt_addr_valid, tgt_claim;
  logic [3:0] mst_cmd, pci_cbe_n_o, tgt_cmd;
  int fail_count, n_checks;
  assign hready = hreadyout;
  gcd_global_cfg i_dut (
    .mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
    .exp_bus_clock_o, .exp_bus_clock_oe, .exp_req, .exp_we, .exp_addr, .exp_wdata, .exp_done, .exp_rdata,
    .exp_bus_req_o, .exp_bus_grant_i, .exp_addr_strobe_n, .exp_dir_o, .exp_data_strobe_n, .exp_addr_o,
    .exp_data_o, .exp_data_oe, .exp_data_i, .irq_a_req, .irq_b_req, .irq_a_n_o, .irq_a_n_oe, .irq_b_n_o,
    .irq_b_n_oe, .group_port_sel, .group_enable, .mst_req, .mst_cmd, .mst_addr, .mst_ready, .mst_addr_done,
    .pci_ad_o, .pci_ad_oe, .pci_cbe_n_o, .pci_cbe_oe, .pci_frame_n_o, .tgt_addr_valid, .tgt_cmd, .tgt_claim);
  gcd_exp_partner i_far (.mclk, .style, .lag, .exp_bus_req_o, .exp_addr_strobe_n, .exp_data_oe,
    .addr_lo(exp_addr_o[7:0]), .exp_bus_grant_i, .exp_data_i);
  // ****
  // Tasks
  // ****
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic mst(input logic [3:0] c, input logic [31:0] a, input int n);
    int k;
    @(posedge mclk);
    mst_req <= 1'b1;
    mst_cmd <= c;
    mst_addr <= a;
    do @(posedge mclk); while (mst_ready !== 1'b1);
    mst_req <= 1'b0;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (mst_addr_done !== 1'b1);
    chk("address clocks", 32'(k), 32'(n));
  endtask
  // Request held until done, since a busy sequencer ignores it
  task automatic xfer(input logic we, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    exp_req <= 1'b1;
    exp_we <= we;
    exp_addr <= a;
    exp_wdata <= d;
    do @(posedge mclk); while (exp_done !== 1'b1);
    exp_req <= 1'b0;
    chk("exp addr", {16'h0, exp_addr_o}, {16'h0, a});
    chk("exp strobes", {30'h0, exp_dir_o, exp_data_strobe_n}, {30'h0, !we, style ? 1'b0 : we});
    if (we) chk("exp wdata", {24'h0, exp_data_o}, {24'h0, d});
    @(posedge mclk);
    if (!we) chk("exp rdata", {24'h0, exp_rdata}, {24'h0, a[7:0] ^ 8'h5a});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****
  // Clock, watchdog and tests
  // ****
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    close_out();
  end
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, style, lag} = '0;
    {exp_req, exp_we, exp_addr, exp_wdata, irq_a_req, irq_b_req} = '0;
    {mst_req, mst_cmd, mst_addr, tgt_addr_valid, tgt_cmd} = '0;
    hsize = 3'h2;
    fail_count = 0;
    n_checks = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    ahb(1'b0, 12'h004, 32'h0);
    chk("upper base", rd, 32'h0);
    ahb(1'b1, 12'h010, 32'hffff_ffff);
    ahb(1'b0, 12'h010, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("clock oe", {31'h0, exp_bus_clock_oe}, 32'h0);
    ahb(1'b1, 12'h000, 32'hffff_ffff);
    ahb(1'b0, 12'h000, 32'h0);
    chk("global cfg", rd, 32'h0000_7f7f);
    @(negedge mclk);
    #1;
    chk("clock pin", {30'h0, exp_bus_clock_oe, exp_bus_clock_o}, 32'h3);
    chk("groups off", {24'h0, group_enable}, 32'h0);
    $display("test registers done");
    for (int j = 0; j < 4; j++) begin
      ahb(1'b1, 12'h000, 32'((j << 2) | (j % 3)));
      irq_a_req <= 1'b1;
      irq_b_req <= 1'b1;
      repeat (2) @(posedge mclk);
      for (int g = 0; g < 8; g++) sel_x[3*g +: 3] = 3'(g >> (j % 3));
      chk("group sel", {8'h0, group_port_sel}, {8'h0, sel_x});
      chk("group en", {24'h0, group_enable}, 32'hff);
      chk("irq oe", {30'h0, irq_a_n_oe, irq_b_n_oe}, 32'(~j & 3));
    end
    $display("test mapping and masks done");
    mst(4'h6, 32'h0000_1000, 2);
    ahb(1'b1, 12'h004, 32'h89ab_cdef);
    ahb(1'b0, 12'h004, 32'h0);
    chk("upper base", rd, 32'h89ab_cdef);
    ahb(1'b0, 12'h008, 32'h0);
    chk("status", rd, 32'h4);
    chk("resp", {31'h0, hresp}, 32'h0);
    mst(4'h7, 32'h0000_2000, 3);
    ahb(1'b1, 12'h004, 32'h0);
    mst(4'h6, 32'h0000_3000, 2);
    for (int j = 0; j < 2; j++) begin
      @(posedge mclk);
      tgt_addr_valid <= 1'b1;
      tgt_cmd <= j ? 4'hd : 4'h6;
      @(posedge mclk);
      tgt_addr_valid <= 1'b0;
      @(posedge mclk);
      chk("claim", {31'h0, tgt_claim}, 32'(1 - j));
    end
    $display("test host bus done");
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    ahb(1'b0, 12'h000, 32'h0);
    chk("reset cfg", rd, 32'h0);
    for (int s = 0; s < 2; s++) begin
      ahb(1'b1, 12'h000, s ? 32'h0000_0d20 : 32'h0000_7b70);
      style <= 1'(s);
      lag <= s ? 2'h3 : 2'h0;
      xfer(1'b1, 16'h1234, 8'ha5);
      xfer(1'b0, 16'h00c3, 8'h00);
      xfer(1'b1, 16'hfffe, 8'h3c);
    end
    $display("test expansion bus done");
    close_out();
  end
endmodule
